// ---- mdfs_top.sv ----
// Fault status bank of a three-phase motor driver behind a 16-bit serial target port
`timescale 1ns/1ps
module mdfs_top
  import mdfs_pkg::*;
(
  input wire logic CLK_SYS_I,                // System clock, 20 MHz
  input wire logic SRST_I,                   // Synchronous reset, active high
  input wire logic CE_I,                     // Clock enable, freezes state when low
  input wire logic CHIP_SELECT_N_I,          // Serial chip select, active low
  input wire logic SPI_SCLK_I,               // Serial clock pin
  input wire logic SPI_SDI_I,                // Serial data in
  output logic SPI_SDO_O,                    // Serial data out
  output logic SPI_SDO_OE_N_O,               // Serial data out enable, active low
  input wire logic THERMAL_WARNING_I,        // Thermal warning detector level
  input wire logic THERMAL_SHUTDOWN_I,       // Thermal shutdown detector level
  input wire logic OC_PHASE_C_HIGH_I,        // Overcurrent phase C high side
  input wire logic OC_PHASE_C_LOW_I,         // Overcurrent phase C low side
  input wire logic OC_PHASE_B_HIGH_I,        // Overcurrent phase B high side
  input wire logic OC_PHASE_B_LOW_I,         // Overcurrent phase B low side
  input wire logic OC_PHASE_A_HIGH_I,        // Overcurrent phase A high side
  input wire logic OC_PHASE_A_LOW_I,         // Overcurrent phase A low side
  input wire logic OTP_ERROR_I,              // Programming memory error level
  input wire logic REG_OVERCURRENT_I,        // Buck regulator overcurrent level
  input wire logic REG_UNDERVOLTAGE_I,       // Buck regulator undervoltage level
  input wire logic CHARGE_PUMP_LOW_I         // Charge pump undervoltage level
);

  localparam int N_PINS = 15;

  // Pin synchronisers
  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_meta;
  logic [N_PINS-1:0] pin_sync;

  assign pin_raw = {CHIP_SELECT_N_I, SPI_SCLK_I, SPI_SDI_I,
                    THERMAL_WARNING_I, THERMAL_SHUTDOWN_I,
                    OC_PHASE_C_HIGH_I, OC_PHASE_C_LOW_I,
                    OC_PHASE_B_HIGH_I, OC_PHASE_B_LOW_I,
                    OC_PHASE_A_HIGH_I, OC_PHASE_A_LOW_I,
                    OTP_ERROR_I, REG_OVERCURRENT_I,
                    REG_UNDERVOLTAGE_I, CHARGE_PUMP_LOW_I};

  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++)
    begin : g_sync
      always_ff @(posedge CLK_SYS_I)
      begin
        if (SRST_I)
        begin
          pin_meta[gi] <= (gi == N_PINS - 1) ? 1'b1 : 1'b0;
          pin_sync[gi] <= (gi == N_PINS - 1) ? 1'b1 : 1'b0;
        end
        else if (CE_I)
        begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic cs_n;
  logic sclk;
  logic sdi;
  logic [7:0] switch_det;
  logic [3:0] supply_det;

  assign cs_n = pin_sync[14];
  assign sclk = pin_sync[13];
  assign sdi = pin_sync[12];
  assign switch_det = pin_sync[11:4];
  assign supply_det = pin_sync[3:0];

  // Edge detection on the synchronised serial pins
  logic cs_n_prev;
  logic sclk_prev;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      cs_n_prev <= 1'b1;
      sclk_prev <= 1'b0;
    end
    else if (CE_I)
    begin
      cs_n_prev <= cs_n;
      sclk_prev <= sclk;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;

  assign cs_fall = cs_n_prev & ~cs_n;
  assign cs_rise = ~cs_n_prev & cs_n;
  assign sclk_fall = sclk_prev & ~sclk;
  assign sclk_rise = ~sclk_prev & sclk;

  // Frame sequencing
  mdfs_state_t state;
  logic [4:0] bit_cnt;
  logic [4:0] rise_cnt;
  logic [15:0] shift_in;
  logic frame_end;
  logic frame_good;

  assign frame_end = (state == ST_FRAME) && cs_rise;
  assign frame_good = frame_end && (bit_cnt == FRAME_BITS);

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      state <= ST_IDLE;
    else if (CE_I)
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (cs_fall)
            state <= ST_FRAME;
        end
        ST_FRAME:
        begin
          if (cs_rise)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Data captured on falling serial clock, MSB first
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      bit_cnt <= 5'h00;
      shift_in <= 16'h0000;
    end
    else if (CE_I)
    begin
      if (state == ST_IDLE && cs_fall)
      begin
        bit_cnt <= 5'h00;
        shift_in <= 16'h0000;
      end
      else if (state == ST_FRAME && sclk_fall)
      begin
        shift_in <= {shift_in[14:0], sdi};
        if (bit_cnt != COUNT_MAX)
          bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // Latched fault flags
  logic clear_pulse;
  logic addr_event;
  logic frame_event;
  logic [6:0] switch_latch;
  logic [3:0] supply_latch;
  logic frame_flag;
  logic addr_flag;
  logic npor_seen;
  logic [5:0] frame_addr;

  assign frame_addr = shift_in[ADDR_MSB:ADDR_LSB];
  assign frame_event = frame_end && (bit_cnt != FRAME_BITS);
  assign addr_event = frame_good && (frame_addr > ADDR_MAP_LAST);

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      switch_latch <= SWITCH_STATUS_RESET[6:0];
      supply_latch <= SUPPLY_STATUS_RESET[6:3];
      frame_flag <= 1'b0;
      addr_flag <= 1'b0;
    end
    else if (CE_I)
    begin
      // A detection in the clearing cycle survives the clear
      switch_latch <= (switch_latch & ~{7{clear_pulse}}) | switch_det[6:0];
      supply_latch <= (supply_latch & ~{4{clear_pulse}}) | supply_det;
      frame_flag <= (frame_flag & ~clear_pulse) | frame_event;
      addr_flag <= (addr_flag & ~clear_pulse) | addr_event;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      npor_seen <= 1'b0;
    else if (CE_I && clear_pulse)
      npor_seen <= 1'b1;
  end

  logic [7:0] switch_status;
  logic [7:0] supply_status;
  logic [7:0] ic_status;

  always_comb
  begin
    switch_status = {switch_det[7], switch_latch};
    supply_status = 8'h00;
    supply_status[SUP_OTP_ERROR_BIT] = supply_latch[3];
    supply_status[SUP_REG_OVERCURRENT_BIT] = supply_latch[2];
    supply_status[SUP_REG_UNDERVOLTAGE_BIT] = supply_latch[1];
    supply_status[SUP_CHARGE_PUMP_LOW_BIT] = supply_latch[0];
    supply_status[SUP_FRAMING_BIT] = frame_flag;
    supply_status[SUP_BAD_ADDRESS_BIT] = addr_flag;
    supply_status = supply_status & SUPPLY_READ_MASK;
    ic_status = 8'h00;
    ic_status[IC_REG_FAULT_BIT] = supply_latch[2] | supply_latch[1];
    ic_status[IC_SERIAL_FAULT_BIT] = frame_flag | addr_flag;
    ic_status[IC_OVERCURRENT_BIT] = |switch_latch[5:0];
    ic_status[IC_NO_POR_BIT] = npor_seen;
    ic_status[IC_THERMAL_BIT] = switch_det[7] | switch_latch[6];
    ic_status[IC_ANY_FAULT_BIT] = (|switch_latch) | (|supply_latch) | frame_flag | addr_flag;
  end

  // Register read at the moment the address is complete
  logic addr_fall;
  logic [5:0] rd_addr;
  logic rd_is_ctrl;
  logic rd_from_mem;
  logic [7:0] status_rd;
  logic [7:0] stat_snap;
  logic [7:0] mem_rd_data;

  assign addr_fall = (state == ST_FRAME) && sclk_fall && (bit_cnt == ADDR_DONE_BITS);
  assign rd_addr = {shift_in[4:0], sdi};
  assign rd_is_ctrl = ((rd_addr >= ADDR_CONTROL_ONE) && (rd_addr <= ADDR_CONTROL_SIX))
                      || (rd_addr == ADDR_CONTROL_TEN);

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      status_rd <= 8'h00;
      rd_from_mem <= 1'b0;
    end
    else if (CE_I)
    begin
      if (state == ST_IDLE && cs_fall)
      begin
        status_rd <= 8'h00;
        rd_from_mem <= 1'b0;
      end
      else if (addr_fall)
      begin
        rd_from_mem <= rd_is_ctrl;
        unique case (rd_addr)
          ADDR_IC_STATUS: status_rd <= ic_status;
          ADDR_SWITCH_STATUS: status_rd <= switch_status;
          ADDR_SUPPLY_STATUS: status_rd <= supply_status;
          default: status_rd <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      stat_snap <= 8'h00;
    else if (CE_I && state == ST_IDLE && cs_fall)
      stat_snap <= ic_status;
  end

  // Writes act only at the end of a complete frame
  logic wr_frame;
  logic [7:0] wr_data;
  logic lock_active;
  logic sdo_push_pull;
  logic mem_wr_en;
  logic [7:0] mem_wr_data;

  assign wr_frame = frame_good && !shift_in[RW_BIT] && (frame_addr <= ADDR_MAP_LAST);
  assign wr_data = shift_in[DATA_MSB:0];

  always_comb
  begin
    mem_wr_en = 1'b0;
    mem_wr_data = wr_data;
    clear_pulse = 1'b0;
    if (wr_frame)
    begin
      if (frame_addr == ADDR_CONTROL_ONE)
      begin
        // Lock field accepts only the two password codes
        if (wr_data[2:0] == LOCK_CODE || wr_data[2:0] == UNLOCK_CODE)
        begin
          mem_wr_en = 1'b1;
          mem_wr_data = wr_data & LOCK_FIELD_MASK;
        end
      end
      else if (frame_addr == ADDR_CONTROL_TWO)
      begin
        if (!lock_active)
        begin
          mem_wr_en = 1'b1;
          mem_wr_data[CLEAR_FAULTS_BIT] = 1'b0;
          clear_pulse = wr_data[CLEAR_FAULTS_BIT];
        end
      end
      else if (((frame_addr >= ADDR_CONTROL_THREE) && (frame_addr <= ADDR_CONTROL_SIX))
               || (frame_addr == ADDR_CONTROL_TEN))
      begin
        mem_wr_en = !lock_active;
      end
      // Status and reserved offsets take no write
      else
      begin
        mem_wr_en = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      lock_active <= 1'b0;
      sdo_push_pull <= CONTROL_TWO_RESET[SDO_PUSH_PULL_BIT];
    end
    else if (CE_I && mem_wr_en)
    begin
      if (frame_addr == ADDR_CONTROL_ONE)
        lock_active <= (wr_data[2:0] == LOCK_CODE);
      else if (frame_addr == ADDR_CONTROL_TWO)
        sdo_push_pull <= wr_data[SDO_PUSH_PULL_BIT];
    end
  end

  mdfs_ctrl_mem u_ctrl_mem (
    .clk_i     (CLK_SYS_I),
    .srst_i    (SRST_I),
    .ce_i      (CE_I),
    .wr_en_i   (mem_wr_en),
    .wr_addr_i (frame_addr[MEM_ADDR_W-1:0]),
    .wr_data_i (mem_wr_data),
    .rd_en_i   (addr_fall && rd_is_ctrl),
    .rd_addr_i (rd_addr[MEM_ADDR_W-1:0]),
    .rd_data_o (mem_rd_data)
  );

  // Response shifted out on rising serial clock: status byte, then register byte
  logic [15:0] resp_word;
  logic next_sdo;
  logic next_drive;
  logic drive;

  assign resp_word = {stat_snap, rd_from_mem ? mem_rd_data : status_rd};

  always_comb
  begin
    next_sdo = SPI_SDO_O;
    next_drive = drive;
    if (state == ST_IDLE && cs_fall)
    begin
      next_sdo = ic_status[7];
      next_drive = 1'b1;
    end
    else if (state == ST_FRAME && cs_rise)
    begin
      next_sdo = 1'b0;
      next_drive = 1'b0;
    end
    else if (state == ST_FRAME && sclk_rise)
    begin
      if (rise_cnt < FRAME_BITS)
        next_sdo = resp_word[4'(5'h0f - rise_cnt)];
      else
        next_sdo = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      rise_cnt <= 5'h00;
    else if (CE_I)
    begin
      if (state == ST_IDLE && cs_fall)
        rise_cnt <= 5'h00;
      else if (state == ST_FRAME && sclk_rise && rise_cnt != COUNT_MAX)
        rise_cnt <= rise_cnt + 5'h01;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      SPI_SDO_O <= 1'b0;
      SPI_SDO_OE_N_O <= 1'b1;
      drive <= 1'b0;
    end
    else if (CE_I)
    begin
      SPI_SDO_O <= next_sdo;
      drive <= next_drive;
      // Open drain mode drives only the low level
      SPI_SDO_OE_N_O <= ~(next_drive && (sdo_push_pull || !next_sdo));
    end
  end

endmodule

// ---- mdfs_pkg.sv ----
// Constants, register map and state type for the motor driver fault status bank
package mdfs_pkg;

  // Register offsets on the 6-bit serial address
  localparam logic [5:0] ADDR_IC_STATUS = 6'h00;
  localparam logic [5:0] ADDR_SWITCH_STATUS = 6'h01;
  localparam logic [5:0] ADDR_SUPPLY_STATUS = 6'h02;
  localparam logic [5:0] ADDR_CONTROL_ONE = 6'h03;
  localparam logic [5:0] ADDR_CONTROL_TWO = 6'h04;
  localparam logic [5:0] ADDR_CONTROL_THREE = 6'h05;
  localparam logic [5:0] ADDR_CONTROL_FOUR = 6'h06;
  localparam logic [5:0] ADDR_CONTROL_FIVE = 6'h07;
  localparam logic [5:0] ADDR_CONTROL_SIX = 6'h08;
  localparam logic [5:0] ADDR_CONTROL_TEN = 6'h0c;
  localparam logic [5:0] ADDR_MAP_LAST = 6'h0c;

  // Switch fault status fields
  localparam int SW_THERMAL_WARNING_BIT = 7;
  localparam int SW_THERMAL_SHUTDOWN_BIT = 6;
  localparam int SW_OC_PHASE_C_HIGH_BIT = 5;
  localparam int SW_OC_PHASE_C_LOW_BIT = 4;
  localparam int SW_OC_PHASE_B_HIGH_BIT = 3;
  localparam int SW_OC_PHASE_B_LOW_BIT = 2;
  localparam int SW_OC_PHASE_A_HIGH_BIT = 1;
  localparam int SW_OC_PHASE_A_LOW_BIT = 0;

  // Supply fault status fields
  localparam int SUP_RESERVED_BIT = 7;
  localparam int SUP_OTP_ERROR_BIT = 6;
  localparam int SUP_REG_OVERCURRENT_BIT = 5;
  localparam int SUP_REG_UNDERVOLTAGE_BIT = 4;
  localparam int SUP_CHARGE_PUMP_LOW_BIT = 3;
  localparam int SUP_PARITY_BIT = 2;
  localparam int SUP_FRAMING_BIT = 1;
  localparam int SUP_BAD_ADDRESS_BIT = 0;

  // Summary status byte sent ahead of every response
  localparam int IC_REG_FAULT_BIT = 6;
  localparam int IC_SERIAL_FAULT_BIT = 5;
  localparam int IC_OVERCURRENT_BIT = 4;
  localparam int IC_NO_POR_BIT = 3;
  localparam int IC_THERMAL_BIT = 1;
  localparam int IC_ANY_FAULT_BIT = 0;

  // Reset values and read masks
  localparam logic [7:0] SWITCH_STATUS_RESET = 8'h00;
  localparam logic [7:0] SUPPLY_STATUS_RESET = 8'h00;
  localparam logic [7:0] SUPPLY_READ_MASK = 8'h7b;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h60;
  localparam logic [7:0] CONTROL_THREE_RESET = 8'h46;
  localparam logic [7:0] CONTROL_OTHER_RESET = 8'h00;

  // Control fields
  localparam int CLEAR_FAULTS_BIT = 0;
  localparam int SDO_PUSH_PULL_BIT = 5;
  localparam logic [7:0] LOCK_FIELD_MASK = 8'h07;
  localparam logic [2:0] LOCK_CODE = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;

  // Serial frame layout
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_DONE_BITS = 5'h06;
  localparam logic [4:0] COUNT_MAX = 5'h1f;
  localparam int RW_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 9;
  localparam int DATA_MSB = 7;

  // Control memory geometry
  localparam int MEM_ADDR_W = 4;
  localparam int MEM_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FRAME = 2'b10
  } mdfs_state_t;

endpackage

// ---- mdfs_ctrl_mem.sv ----
// Control register storage with per-entry reset values and registered read
`timescale 1ns/1ps
module mdfs_ctrl_mem
  import mdfs_pkg::*;
(
  input wire logic clk_i,                    // System clock
  input wire logic srst_i,                   // Synchronous reset, active high
  input wire logic ce_i,                     // Clock enable
  input wire logic wr_en_i,                  // Write strobe
  input wire logic [MEM_ADDR_W-1:0] wr_addr_i, // Write address
  input wire logic [7:0] wr_data_i,          // Write data
  input wire logic rd_en_i,                  // Read strobe
  input wire logic [MEM_ADDR_W-1:0] rd_addr_i, // Read address
  output logic [7:0] rd_data_o               // Registered read data
);

  logic [7:0] mem [MEM_DEPTH];

  function automatic logic [7:0] entry_reset(input int idx);
    logic [7:0] val;
    val = CONTROL_OTHER_RESET;
    if (idx == int'(ADDR_CONTROL_ONE))
      val = CONTROL_ONE_RESET;
    else if (idx == int'(ADDR_CONTROL_TWO))
      val = CONTROL_TWO_RESET;
    else if (idx == int'(ADDR_CONTROL_THREE))
      val = CONTROL_THREE_RESET;
    return val;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < MEM_DEPTH; gi++)
    begin : g_entry
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          mem[gi] <= entry_reset(gi);
        else if (ce_i && wr_en_i && (wr_addr_i == MEM_ADDR_W'(gi)))
          mem[gi] <= wr_data_i;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rd_data_o <= 8'h00;
    else if (ce_i && rd_en_i)
      rd_data_o <= mem[rd_addr_i];
  end

endmodule

// ---- mdfs_monitor.sv ----
// Port checker for the serial target side of the fault status bank
`timescale 1ns/1ps
module mdfs_monitor (
  input wire logic CLK_SYS_I,       // System clock
  input wire logic SRST_I,          // Synchronous reset, active high
  input wire logic CHIP_SELECT_N_I, // Serial chip select, active low
  input wire logic SPI_SCLK_I,      // Serial clock pin
  input wire logic SPI_SDO_O,       // Serial data out
  input wire logic SPI_SDO_OE_N_O   // Serial data out enable, active low
);
  logic cs_q;
  logic sclk_q;
  logic [3:0] quiet_cnt;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SRST_I);

  always_ff @(posedge CLK_SYS_I)
  begin
    cs_q <= CHIP_SELECT_N_I;
    sclk_q <= SPI_SCLK_I;
  end

  // Cycles since the last edge on either serial control pin
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I || cs_q != CHIP_SELECT_N_I || sclk_q != SPI_SCLK_I)
      quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hf)
      quiet_cnt <= quiet_cnt + 4'h1;
  end

  reset_idle_a: assert property ($fell(SRST_I) |-> SPI_SDO_OE_N_O && !SPI_SDO_O)
    else $error("serial output not idle after reset");
  idle_released_a: assert property (CHIP_SELECT_N_I [*8] |-> SPI_SDO_OE_N_O && !SPI_SDO_O)
    else $error("serial output driven while deselected");
  cs_rise_release_a: assert property ($rose(CHIP_SELECT_N_I) |-> ##[1:7] SPI_SDO_OE_N_O)
    else $error("serial output not released after frame end");
  cs_fall_drive_a: assert property ($fell(CHIP_SELECT_N_I) ##1 !CHIP_SELECT_N_I [*6] |-> !SPI_SDO_OE_N_O)
    else $error("serial output not driven after frame start");
  first_bit_zero_a: assert property ($fell(CHIP_SELECT_N_I) ##1 !CHIP_SELECT_N_I [*6] |-> !SPI_SDO_O)
    else $error("first response bit not zero");
  sdo_quiet_a: assert property (quiet_cnt >= 4'h6 |-> $stable(SPI_SDO_O))
    else $error("serial data changed without a clock edge");
  oe_quiet_a: assert property (quiet_cnt >= 4'h6 |-> $stable(SPI_SDO_OE_N_O))
    else $error("output enable changed without a clock edge");
  oe_in_frame_a: assert property ($fell(SPI_SDO_OE_N_O) |-> !CHIP_SELECT_N_I)
    else $error("output enabled outside a frame");
endmodule

bind mdfs_top mdfs_monitor mon (
  .CLK_SYS_I(CLK_SYS_I),
  .SRST_I(SRST_I),
  .CHIP_SELECT_N_I(CHIP_SELECT_N_I),
  .SPI_SCLK_I(SPI_SCLK_I),
  .SPI_SDO_O(SPI_SDO_O),
  .SPI_SDO_OE_N_O(SPI_SDO_OE_N_O)
);

// ---- mdfs_host_model.sv ----
// Serial controller model standing in for the host microcontroller
`timescale 1ns/1ps
module mdfs_host_model (
  input wire logic clk_i,      // System clock
  output logic cs_n_o,         // Chip select, active low
  output logic sclk_o,         // Serial clock, idle low
  output logic sdi_o,          // Serial data to the target
  input wire logic sdo_i,      // Serial data from the target
  input wire logic sdo_oe_n_i  // Target output enable, active low
);
  localparam int HALF = 8;

  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  // A bit count other than 16 is only used to provoke a framing fault
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] resp);
    resp = 16'h0000;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    for (int i = 0; i < nbits; i++)
    begin
      sclk_o <= 1'b1;
      sdi_o <= (i < 16) ? word[15 - i] : 1'b0;
      repeat (HALF) @(posedge clk_i);
      // Released line reads as pulled up
      if (i < 16)
        resp[15 - i] = sdo_oe_n_i ? 1'b1 : sdo_i;
      sclk_o <= 1'b0;
      repeat (HALF) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (12) @(posedge clk_i);
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the motor driver fault status bank
`timescale 1ns/1ps
module tb_top
  import mdfs_pkg::*;
;
  logic clk;
  logic srst;
  logic ce;
  logic [11:0] flt;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic [15:0] resp;
  int n_errors;
  int compares;
  int cycles;
  int bad_bits [4] = '{8, 17, 16, 16};
  logic [7:0] bad_flag [4] = '{8'h02, 8'h02, 8'h01, 8'h01};
  logic [5:0] ctl_addr [5] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h0c};

  mdfs_top dut (
    .CLK_SYS_I(clk),
    .SRST_I(srst),
    .CE_I(ce),
    .CHIP_SELECT_N_I(cs_n),
    .SPI_SCLK_I(sclk),
    .SPI_SDI_I(sdi),
    .SPI_SDO_O(sdo),
    .SPI_SDO_OE_N_O(sdo_oe_n),
    .THERMAL_WARNING_I(flt[7]),
    .THERMAL_SHUTDOWN_I(flt[6]),
    .OC_PHASE_C_HIGH_I(flt[5]),
    .OC_PHASE_C_LOW_I(flt[4]),
    .OC_PHASE_B_HIGH_I(flt[3]),
    .OC_PHASE_B_LOW_I(flt[2]),
    .OC_PHASE_A_HIGH_I(flt[1]),
    .OC_PHASE_A_LOW_I(flt[0]),
    .OTP_ERROR_I(flt[11]),
    .REG_OVERCURRENT_I(flt[10]),
    .REG_UNDERVOLTAGE_I(flt[9]),
    .CHARGE_PUMP_LOW_I(flt[8])
  );

  mdfs_host_model host (
    .clk_i(clk),
    .cs_n_o(cs_n),
    .sclk_o(sclk),
    .sdi_o(sdi),
    .sdo_i(sdo),
    .sdo_oe_n_i(sdo_oe_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Even parity over the whole word
  function automatic logic [15:0] frame(input logic rw, input logic [5:0] a, input logic [7:0] v);
    return {rw, a, ^{rw, a, v}, v};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [15:0] r;
    host.xfer(frame(1'b1, a, 8'h00), 16, r);
    check($sformatf("read %h", a), r[7:0], exp);
  endtask

  // Response byte of a write is the value held before it
  task automatic wr_chk(input logic [5:0] a, input logic [7:0] v, input logic [7:0] old);
    logic [15:0] r;
    host.xfer(frame(1'b0, a, v), 16, r);
    check($sformatf("write %h", a), r[7:0], old);
  endtask

  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    flt = 12'h000;
    tick(8);
    srst <= 1'b0;
    tick(6);
    rd_chk(ADDR_SWITCH_STATUS, SWITCH_STATUS_RESET);
    rd_chk(ADDR_SUPPLY_STATUS, SUPPLY_STATUS_RESET);
    rd_chk(ADDR_CONTROL_TWO, CONTROL_TWO_RESET);
    $display("reset values test done");
    for (int i = 0; i < 12; i++)
    begin
      flt[i] <= 1'b1;
      tick(6);
      if (i != 7)
        flt[i] <= 1'b0;
      tick(6);
      rd_chk(i < 8 ? 6'h01 : 6'h02, i < 8 ? 8'h01 << i : 8'h01 << (i - 5));
      flt[i] <= 1'b0;
      tick(6);
      wr_chk(ADDR_CONTROL_TWO, 8'h61, CONTROL_TWO_RESET);
      rd_chk(i < 8 ? 6'h01 : 6'h02, 8'h00);
    end
    $display("fault flags test done");
    flt[0] <= 1'b1;
    tick(6);
    flt[0] <= 1'b0;
    wr_chk(ADDR_SWITCH_STATUS, 8'h00, 8'h01);
    rd_chk(ADDR_IC_STATUS, 8'h19);
    rd_chk(ADDR_SWITCH_STATUS, 8'h01);
    wr_chk(ADDR_SUPPLY_STATUS, 8'hff, 8'h00);
    rd_chk(ADDR_SUPPLY_STATUS, 8'h00);
    wr_chk(ADDR_CONTROL_TWO, 8'h61, CONTROL_TWO_RESET);
    host.xfer(frame(1'b1, ADDR_CONTROL_ONE, 8'h00) ^ 16'h0100, 16, resp);
    rd_chk(ADDR_SUPPLY_STATUS, 8'h00);
    $display("read-only test done");
    for (int k = 0; k < 4; k++)
    begin
      host.xfer(k < 2 ? frame(1'b0, 6'h08, 8'h33) : frame(1'b1, k == 2 ? 6'h0d : 6'h3f, 8'h00),
                bad_bits[k], resp);
      rd_chk(ADDR_CONTROL_SIX, 8'h00);
      rd_chk(ADDR_SUPPLY_STATUS, bad_flag[k]);
      wr_chk(ADDR_CONTROL_TWO, 8'h61, CONTROL_TWO_RESET);
    end
    $display("serial error test done");
    for (int k = 0; k < 5; k++)
    begin
      wr_chk(ctl_addr[k], 8'h5a, k == 0 ? CONTROL_THREE_RESET : CONTROL_OTHER_RESET);
      rd_chk(ctl_addr[k], 8'h5a);
    end
    wr_chk(ADDR_CONTROL_ONE, {5'h00, LOCK_CODE}, CONTROL_ONE_RESET);
    rd_chk(ADDR_CONTROL_ONE, {5'h00, LOCK_CODE});
    wr_chk(ADDR_CONTROL_SIX, 8'h11, 8'h5a);
    rd_chk(ADDR_CONTROL_SIX, 8'h5a);
    wr_chk(ADDR_CONTROL_ONE, 8'h05, {5'h00, LOCK_CODE});
    wr_chk(ADDR_CONTROL_SIX, 8'h11, 8'h5a);
    wr_chk(ADDR_CONTROL_ONE, {5'h00, UNLOCK_CODE}, {5'h00, LOCK_CODE});
    wr_chk(ADDR_CONTROL_SIX, 8'h11, 8'h5a);
    rd_chk(ADDR_CONTROL_SIX, 8'h11);
    // Open drain output: released bits read back through the pull-up
    wr_chk(ADDR_CONTROL_TWO, 8'h40, CONTROL_TWO_RESET);
    rd_chk(ADDR_CONTROL_THREE, 8'h5a);
    rd_chk(ADDR_CONTROL_TWO, 8'h40);
    $display("control and lock test done");
    test_done();
  end
endmodule
